// ===== common/cfg_pins_pkg.sv
// constants, types and state list for the configuration pin controller
// assumes one 200 MHz clock and pins already synchronous to it
`default_nettype none
package cfg_pins_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 5; // system clock period
  localparam int INIT_TIME_NS = 1000; // internal clear time before download
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_DIV = 4; // flash clock toggles every SCK_DIV cycles
  localparam logic [7:0] FLASH_READ_CMD = 8'h03; // serial read command
  localparam logic [7:0] FLASH_QREAD_CMD = 8'h6B; // quad output read command
  localparam logic [23:0] FLASH_START_ADDR = 24'h000000; // image start address
  localparam int HDR_BITS = 32; // command plus address bits
  localparam int DUMMY_BITS = 8; // quad read dummy clocks
  localparam logic [9:0] INIT_CNT_RST = 10'h000; // counter value after reset
  localparam logic [15:0] GPIO_DIR_RST = 16'h0000; // user direction after reset

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    ST_USER,   // running user operation
    ST_INIT,   // clearing, init pin low
    ST_WAIT,   // init released, waiting for line high
    ST_HDR,    // shifting command and address
    ST_DATA,   // reading image data
    ST_WAKE    // completion released, waiting for line high
  } cfg_state_t;

  typedef struct packed {
    logic out; // value to drive
    logic oe_n; // low while driving
  } pin_drive_t;

  typedef struct packed {
    logic tdi;
    logic tms;
    logic tck;
  } scan_in_t;

endpackage
`default_nettype wire

// ===== logic/cfg_pin_control.sv
// configuration sequencer and shared pin multiplexer
// assumes pin inputs synchronous to clk_sys, pull-ups on the status pins
`timescale 1ns/10ps
`default_nettype none
module cfg_pin_control
  import cfg_pins_pkg::*;
(
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rstn, // async reset, active low
  input wire logic config_request_n, // configuration request pin
  input wire logic init_status_n_in, // init status line level
  output logic init_status_n_out, // init status drive value
  output logic init_status_n_oe_n, // init status enable, low drives
  input wire logic done_status_n_in, // completion line level
  output logic done_status_n_out, // completion drive value
  output logic done_status_n_oe_n, // completion enable, low drives
  input wire logic quad_mode, // strap: quad instead of serial read
  input wire logic [31:0] image_len_bits, // bits of image to read
  output logic boot_flash_sck, // flash serial clock
  output logic boot_flash_sck_oe_n, // flash clock enable, low drives
  output logic boot_flash_select_n, // flash chip select
  output logic boot_flash_select_n_oe_n, // chip select enable, low drives
  input wire logic boot_flash_quad_io0_in, // io0 level
  output logic boot_flash_quad_io0_out, // serial out / io0 value
  output logic boot_flash_quad_io0_oe_n, // io0 enable, low drives
  input wire logic boot_flash_quad_io1_in, // serial in / io1 level
  output logic boot_flash_quad_io1_out, // io1 value
  output logic boot_flash_quad_io1_oe_n, // io1 enable, low drives
  output logic [3:0] cfg_data, // image data, low bit when serial, low two bits when quad
  output logic cfg_data_valid, // one-cycle pulse per sample
  output logic user_mode, // device in user operation
  input wire logic scan_select, // test port select
  input wire pin_drive_t [3:0] user_scan_drive, // user drive of tdi,tdo,tms,tck pins
  input wire logic [3:0] scan_pin_in, // scan pin levels: tck,tms,tdo,tdi
  output pin_drive_t [3:0] scan_pin_drive, // scan pin drive
  input wire logic scan_tdo, // test port data out
  output scan_in_t scan_port, // test port inputs
  output logic [3:0] user_scan_in // scan pins seen by user logic
);

  // ==========================================================
  // state and counters
  // ==========================================================
  cfg_state_t state; // sequence state
  logic [9:0] init_cnt; // initialization timer
  logic [2:0] div_cnt; // flash clock divider
  logic sck_en; // one-cycle enable at divider wrap
  logic [31:0] bit_cnt; // bits or clocks left in phase
  logic [31:0] hdr_sr; // command and address shifter
  logic [31:0] next_bit_cnt; // shared decrement
  logic in_cfg; // inside configuration

  assign in_cfg = (state != ST_USER);
  assign next_bit_cnt = bit_cnt - 32'h00000001;

  // divider produces the flash clock rate as an enable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 3'h0;
    end else if (div_cnt == 3'(SCK_DIV - 1)) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end
  assign sck_en = (div_cnt == 3'(SCK_DIV - 1));

  // ==========================================================
  // sequencer
  // ==========================================================
  // a request is honoured in any state so a stuck load can be restarted
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_INIT;
      init_cnt <= INIT_CNT_RST;
      bit_cnt <= 32'h00000000;
      hdr_sr <= 32'h00000000;
      boot_flash_sck <= 1'b0;
    end else if (!config_request_n) begin
      state <= ST_INIT;
      init_cnt <= INIT_CNT_RST;
      boot_flash_sck <= 1'b0;
    end else begin
      case (state)
        ST_INIT: begin
          if (init_cnt == 10'(INIT_CYCLES - 1)) begin
            state <= ST_WAIT;
          end else begin
            init_cnt <= init_cnt + 10'h001;
          end
        end
        ST_WAIT: begin
          // host may stretch the init line low
          if (init_status_n_in && sck_en) begin
            state <= ST_HDR;
            hdr_sr <= {quad_mode ? FLASH_QREAD_CMD : FLASH_READ_CMD, FLASH_START_ADDR};
            bit_cnt <= 32'(HDR_BITS);
          end
        end
        ST_HDR: begin
          if (sck_en) begin
            boot_flash_sck <= ~boot_flash_sck;
            if (boot_flash_sck) begin
              // falling edge shifts next command bit
              hdr_sr <= {hdr_sr[30:0], 1'b0};
              bit_cnt <= next_bit_cnt;
              if (bit_cnt == 32'h00000001) begin
                state <= ST_DATA;
                bit_cnt <= quad_mode ? (image_len_bits >> 2) + 32'(DUMMY_BITS) : image_len_bits;
              end
            end
          end
        end
        ST_DATA: begin
          if (sck_en) begin
            boot_flash_sck <= ~boot_flash_sck;
            if (boot_flash_sck) begin
              bit_cnt <= next_bit_cnt;
              if (bit_cnt == 32'h00000001) begin
                state <= ST_WAKE;
              end
            end
          end
        end
        ST_WAKE: begin
          // host may hold completion low to delay wake-up
          if (done_status_n_in) begin
            state <= ST_USER;
          end
        end
        ST_USER: begin
          state <= ST_USER;
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end

  // ==========================================================
  // data capture
  // ==========================================================
  // sampled on the rising flash clock edge, dummy clocks skipped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_data <= 4'h0;
      cfg_data_valid <= 1'b0;
    end else begin
      cfg_data_valid <= 1'b0;
      if (state == ST_DATA && sck_en && !boot_flash_sck && config_request_n) begin
        if (!quad_mode) begin
          cfg_data <= {3'h0, boot_flash_quad_io1_in};
          cfg_data_valid <= 1'b1;
        end else if (bit_cnt <= (image_len_bits >> 2)) begin
          // upper two quad lines live on other pins, not here
          cfg_data <= {2'h0, boot_flash_quad_io1_in, boot_flash_quad_io0_in};
          cfg_data_valid <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // configuration pin drivers
  // ==========================================================
  // status pins: drive value fixed low, only enable moves
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      init_status_n_out <= 1'b0;
      done_status_n_out <= 1'b0;
      init_status_n_oe_n <= 1'b0;
      done_status_n_oe_n <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      init_status_n_oe_n <= !(state == ST_INIT || !config_request_n);
      done_status_n_oe_n <= !(in_cfg && state != ST_WAKE) && config_request_n;
      user_mode <= (state == ST_USER) && config_request_n;
    end
  end

  // flash pins: driven only during the master read, select also driven while waiting, else released
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot_flash_sck_oe_n <= 1'b1;
      boot_flash_select_n <= 1'b1;
      boot_flash_select_n_oe_n <= 1'b1;
      boot_flash_quad_io0_out <= 1'b0;
      boot_flash_quad_io0_oe_n <= 1'b1;
      boot_flash_quad_io1_out <= 1'b0;
      boot_flash_quad_io1_oe_n <= 1'b1;
    end else begin
      boot_flash_sck_oe_n <= !(state == ST_HDR || state == ST_DATA);
      boot_flash_select_n_oe_n <= !(state == ST_WAIT || state == ST_HDR || state == ST_DATA);
      boot_flash_select_n <= !(state == ST_HDR || state == ST_DATA);
      boot_flash_quad_io0_out <= hdr_sr[31];
      boot_flash_quad_io0_oe_n <= !(state == ST_HDR);
      boot_flash_quad_io1_out <= 1'b0;
      boot_flash_quad_io1_oe_n <= 1'b1;
    end
  end

  // ==========================================================
  // shared scan pins
  // ==========================================================
  // index 0 tdi, 1 tdo, 2 tms, 3 tck
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scan_pin_drive <= {4{pin_drive_t'{out: 1'b0, oe_n: 1'b1}}};
      scan_port <= '0;
      user_scan_in <= 4'h0;
    end else if (scan_select) begin
      // only tdo leaves the test port; tdi, tms, tck stay released so the tester owns them
      scan_pin_drive <= {pin_drive_t'{out: 1'b0, oe_n: 1'b1}, pin_drive_t'{out: 1'b0, oe_n: 1'b1},
        pin_drive_t'{out: scan_tdo, oe_n: 1'b0}, pin_drive_t'{out: 1'b0, oe_n: 1'b1}};
      scan_port <= '{tdi: scan_pin_in[0], tms: scan_pin_in[2], tck: scan_pin_in[3]};
      user_scan_in <= 4'h0;
    end else if (user_mode) begin
      scan_pin_drive <= user_scan_drive;
      scan_port <= '0;
      user_scan_in <= scan_pin_in;
    end else begin
      scan_pin_drive <= {4{pin_drive_t'{out: 1'b0, oe_n: 1'b1}}};
      scan_port <= '0;
      user_scan_in <= 4'h0;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  start_init_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !config_request_n |=> ##1 !init_status_n_oe_n) else $error("init not pulled low");
  init_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_WAIT && config_request_n) |=> init_status_n_oe_n) else $error("init held");
  hold_download_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_WAIT && !init_status_n_in) |=> state != ST_HDR) else $error("download early");
  done_low_cfg_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_DATA && config_request_n) |=> !done_status_n_oe_n) else $error("done released");
  done_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_WAKE && config_request_n) |=> done_status_n_oe_n) else $error("done not released");
  wake_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_WAKE && !done_status_n_in) |=> state != ST_USER) else $error("early wake");
  status_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !init_status_n_out && !done_status_n_out) else $error("status driven high");
  scan_route_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_select |=> scan_port.tck == $past(scan_pin_in[3]) && !scan_pin_drive[1].oe_n && scan_pin_drive[3].oe_n)
    else $error("scan not routed");
  user_route_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!scan_select && user_mode) |=> scan_pin_drive == $past(user_scan_drive))
    else $error("user pins not routed");
  flash_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_USER) |=> boot_flash_sck_oe_n && boot_flash_select_n_oe_n) else $error("flash driven");
  flash_cs_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_HDR && config_request_n) |=> !boot_flash_select_n && !boot_flash_sck_oe_n)
    else $error("flash not selected");

  full_load_c: cover property (@(posedge clk_sys) disable iff (!rstn) state == ST_WAKE ##1 state == ST_USER);
  init_stall_c: cover property (@(posedge clk_sys) disable iff (!rstn) state == ST_WAIT && !init_status_n_in);
  quad_data_c: cover property (@(posedge clk_sys) disable iff (!rstn) cfg_data_valid && quad_mode);
  scan_use_c: cover property (@(posedge clk_sys) disable iff (!rstn) user_mode && scan_select);

endmodule
`default_nettype wire

// ===== dv/boot_host_model.sv
// host and boot flash beside the configuration pin controller
// assumes pull-ups on both status lines and a mode 0 flash
`timescale 1ns/10ps
`default_nettype none
module boot_host_model (
  input wire logic sck, // flash clock
  input wire logic sel_n, // flash chip select
  input wire logic quad, // quad read expected
  input wire logic io0_out, // device io0 value
  input wire logic io0_oe_n, // device io0 enable
  input wire logic init_oe_n, // device init pull
  input wire logic done_oe_n, // device done pull
  input wire logic hold_init, // host holds init low
  input wire logic hold_done, // host holds done low
  output logic io0_in, // wired io0
  output logic io1_in, // wired io1
  output logic init_in, // wired init line
  output logic done_in, // wired done line
  output logic [31:0] hdr // first bits seen on io0
);
  localparam logic [7:0] PAT = 8'hA5; // image pattern, msb first
  logic [15:0] rises = 16'h0000; // rising clocks this frame
  logic [2:0] idx = 3'h7; // pattern bit in flight
  logic drv = 1'b0; // flash drives data
  logic [1:0] val = 2'h0; // data on io1,io0
  logic [1:0] flt = 2'h0; // undriven level, never the last value
  // ==========================================
  // wired lines
  // ==========================================
  // pull-up, low if either party pulls
  assign init_in = !(!init_oe_n || hold_init);
  assign done_in = !(!done_oe_n || hold_done);
  assign io0_in = !io0_oe_n ? io0_out : (drv && quad ? val[0] : flt[0]);
  assign io1_in = drv ? val[1] : flt[1];
  // ==========================================
  // flash
  // ==========================================
  // header capture on rising clock
  always @(posedge sck or posedge sel_n) begin
    if (sel_n)
      rises <= 16'h0000;
    else begin
      if (rises < 16'h0020)
        hdr <= {hdr[30:0], io0_out};
      rises <= rises + 16'h0001;
    end
  end
  // data launched on falling clock after header and dummies
  always @(negedge sck or posedge sel_n) begin
    flt <= ~flt;
    if (sel_n) begin
      drv <= 1'b0;
      idx <= 3'h7;
    end else if (rises >= (quad ? 16'h0028 : 16'h0020)) begin
      drv <= 1'b1;
      val <= {PAT[idx], ~PAT[idx]};
      idx <= idx - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/config_handshake_pin_control_test.sv
// self-checking bench of the configuration pin controller
// assumes the host and flash model; inputs change on falling edges
`timescale 1ns/10ps
`default_nettype none
module config_handshake_pin_control_test;
  import cfg_pins_pkg::*;
  localparam logic [7:0] PAT = 8'hA5; // flash image pattern
  logic clk_sys = 1'b0, rstn = 1'b0, config_request_n = 1'b1, quad_mode = 1'b0;
  logic scan_select = 1'b0, scan_tdo = 1'b0, hold_init = 1'b0, hold_done = 1'b0;
  logic [31:0] image_len_bits = 32'h00000010, hdr;
  pin_drive_t [3:0] user_scan_drive = 8'hFF, scan_pin_drive;
  logic [3:0] scan_pin_in = 4'h0, cfg_data, user_scan_in, smp [0:63];
  logic init_status_n_in, init_status_n_out, init_status_n_oe_n, done_status_n_in;
  logic done_status_n_out, done_status_n_oe_n, boot_flash_sck, boot_flash_sck_oe_n;
  logic boot_flash_select_n, boot_flash_select_n_oe_n, boot_flash_quad_io0_in;
  logic boot_flash_quad_io0_out, boot_flash_quad_io0_oe_n, boot_flash_quad_io1_in;
  logic boot_flash_quad_io1_out, boot_flash_quad_io1_oe_n, cfg_data_valid, user_mode;
  scan_in_t scan_port;
  int errors = 0, comparisons = 0, nsmp = 0;
  // ==========================================
  // clock, design and partner
  // ==========================================
  always #2.5 clk_sys = ~clk_sys;
  cfg_pin_control i_cfg_pin_control (.clk_sys, .rstn, .config_request_n,
    .init_status_n_in, .init_status_n_out, .init_status_n_oe_n, .done_status_n_in,
    .done_status_n_out, .done_status_n_oe_n, .quad_mode, .image_len_bits,
    .boot_flash_sck, .boot_flash_sck_oe_n, .boot_flash_select_n, .boot_flash_select_n_oe_n,
    .boot_flash_quad_io0_in, .boot_flash_quad_io0_out, .boot_flash_quad_io0_oe_n,
    .boot_flash_quad_io1_in, .boot_flash_quad_io1_out, .boot_flash_quad_io1_oe_n,
    .cfg_data, .cfg_data_valid, .user_mode, .scan_select, .user_scan_drive,
    .scan_pin_in, .scan_pin_drive, .scan_tdo, .scan_port, .user_scan_in);
  boot_host_model i_boot_host_model (.sck(boot_flash_sck), .sel_n(boot_flash_select_n),
    .quad(quad_mode), .io0_out(boot_flash_quad_io0_out), .io0_oe_n(boot_flash_quad_io0_oe_n),
    .init_oe_n(init_status_n_oe_n), .done_oe_n(done_status_n_oe_n), .hold_init, .hold_done,
    .io0_in(boot_flash_quad_io0_in), .io1_in(boot_flash_quad_io1_in),
    .init_in(init_status_n_in), .done_in(done_status_n_in), .hdr);
  // sample log, a 64-entry ring so a task only notes where it began
  always @(posedge clk_sys) begin
    if (cfg_data_valid === 1'b1) begin
      smp[nsmp % 64] <= cfg_data;
      nsmp <= nsmp + 1;
    end
  end
  // ==========================================
  // helpers
  // ==========================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // scenarios
  // ==========================================
  task automatic test_reset;
    repeat (2) @(negedge clk_sys);
    check(init_status_n_oe_n, 0, "init pull in reset");
    check(done_status_n_oe_n, 0, "done pull in reset");
    check(boot_flash_quad_io1_oe_n, 1, "io1 released");
    check(scan_pin_drive[0].oe_n, 1, "scan pin released");
    $display("test_reset done");
  endtask
  task automatic test_serial;
    int i, base;
    hold_init = 1'b1;
    hold_done = 1'b1;
    repeat (220) @(negedge clk_sys);
    check(init_status_n_oe_n, 1, "init released");
    check(boot_flash_select_n, 1, "download held off");
    hold_init = 1'b0;
    base = nsmp;
    for (i = 0; i < 100 && boot_flash_select_n !== 1'b0; i++) @(negedge clk_sys);
    check(boot_flash_select_n, 0, "download started");
    check(boot_flash_quad_io0_oe_n, 0, "serial out driven");
    check(scan_pin_drive, 8'h55, "scan pins tri-stated");
    check(boot_flash_sck_oe_n, 0, "flash clock driven");
    check(boot_flash_select_n_oe_n, 0, "select driven");
    check(boot_flash_quad_io1_oe_n, 1, "serial in undriven");
    check(done_status_n_oe_n, 0, "done pulled");
    check(init_status_n_out, 0, "init never high");
    for (i = 0; i < 2000 && done_status_n_oe_n !== 1'b1; i++) @(negedge clk_sys);
    check(done_status_n_oe_n, 1, "done released");
    check(hdr, {FLASH_READ_CMD, FLASH_START_ADDR}, "serial header");
    check(nsmp - base, 16, "sample count");
    for (i = 0; i < 16; i++) check(smp[(base + i) % 64][0], PAT[7 - i % 8], "serial bit");
    repeat (20) @(negedge clk_sys);
    check(done_status_n_out, 0, "done never high");
    check(user_mode, 0, "wake held off");
    hold_done = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(user_mode, 1, "user mode");
    $display("test_serial done");
  endtask
  task automatic test_quad;
    int i, base;
    quad_mode = 1'b1;
    config_request_n = 1'b0;
    @(negedge clk_sys);
    config_request_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(init_status_n_oe_n, 0, "restart pulls init");
    check(user_mode, 0, "left user mode");
    base = nsmp;
    for (i = 0; i < 2000 && user_mode !== 1'b1; i++) @(negedge clk_sys);
    check(user_mode, 1, "quad wake");
    check(hdr, {FLASH_QREAD_CMD, FLASH_START_ADDR}, "quad header");
    check(nsmp - base, 4, "quad samples");
    for (i = 0; i < 4; i++) check(smp[(base + i) % 64][1:0], {PAT[7 - i], ~PAT[7 - i]}, "quad pair");
    $display("test_quad done");
  endtask
  task automatic test_scan;
    scan_pin_in = 4'h5;
    scan_tdo = 1'b1;
    scan_select = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(scan_port, 3'h6, "test port inputs");
    check(scan_pin_drive[1], 2'h2, "tdo driven");
    check(scan_pin_drive, 8'h59, "only tdo driven");
    scan_select = 1'b0;
    user_scan_drive = 8'h4E;
    repeat (3) @(negedge clk_sys);
    check(scan_pin_drive, 8'h4E, "user drive");
    check(user_scan_in, 4'h5, "user sees pins");
    $display("test_scan done");
  endtask
  // ==========================================
  // sequence and watchdog
  // ==========================================
  initial begin
    test_reset();
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    test_serial();
    test_quad();
    test_scan();
    finish_test();
  end
  // whole run needs about 1200 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
